// >>> fpf_pkg.sv
// Shared constants for the fan power and fail-safe controller
package fpf_pkg;
  // Clock and timebase
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam real         COUNT_US  = 552.5;
  localparam int unsigned COUNT_CYC = int'(COUNT_US * real'(CLK_HZ) / 1.0e6);
  localparam real         EIGHTH_S  = 0.125;
  localparam int unsigned TICK_CYC  = int'(EIGHTH_S * real'(CLK_HZ));
  localparam logic [6:0]  PWM_LAST  = 7'h63;
  // Power and delay values
  localparam logic [7:0]  FULL_POWER = 8'h64;
  localparam logic [7:0]  DELAY_DEF  = 8'h01;
  localparam logic [7:0]  POWER_DEF  = 8'h64;
  // Packet codes
  localparam logic [7:0]  ACK_BIT      = 8'h40;
  localparam logic [7:0]  ERR_BITS     = 8'hC0;
  localparam logic [7:0]  CMD_STORE    = 8'h04;
  localparam logic [7:0]  CMD_REPORT   = 8'h10;
  localparam logic [7:0]  CMD_POWER    = 8'h11;
  localparam logic [7:0]  CMD_FAILSAFE = 8'h19;
  localparam logic [7:0]  CMD_GLITCH   = 8'h1A;
  localparam logic [7:0]  CMD_QUERY    = 8'h1B;
  localparam logic [7:0]  LEN_NONE     = 8'h00;
  localparam logic [7:0]  LEN_REPORT   = 8'h01;
  localparam logic [7:0]  LEN_FAILSAFE = 8'h02;
  localparam logic [7:0]  LEN_FOUR     = 8'h04;
  localparam logic [7:0]  LEN_QUERY    = 8'h05;
  // Register byte offsets
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_CMD_DATA  = 8'h04;
  localparam logic [7:0]  OFS_RSP       = 8'h08;
  localparam logic [7:0]  OFS_RSP_DATA  = 8'h0C;
  localparam logic [7:0]  OFS_RSP_DATA1 = 8'h10;
  localparam logic [7:0]  OFS_TACH      = 8'h14;
  localparam logic [7:0]  OFS_STATUS    = 8'h18;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// >>> fpf_reg_if.sv
// Register access carrier between the bus slave and the controller core
`timescale 1ns/1ps
interface fpf_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_ok, rd_data, rd_ok);
  modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface

// >>> fpf_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
module fpf_axil (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core side
  fpf_reg_if.slave         rb
);
  logic        aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid, do_wr;
  logic [1:0]  next_bresp, next_rresp;

  // Address and data are held until both are in, so either order works
  assign awready    = !aw_full;
  assign wready     = !w_full;
  assign arready    = !rvalid;
  assign do_wr      = aw_full && w_full && !bvalid;
  assign rb.wr_en   = do_wr;
  assign rb.wr_addr = {aw_addr[7:2], 2'b00};
  assign rb.wr_data = w_data;
  assign rb.wr_strb = w_strb;
  assign rb.rd_en   = arvalid && !rvalid;
  assign rb.rd_addr = {araddr[7:2], 2'b00};

  // Next state of both channel pairs
  always_comb
  begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && !aw_full)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && !w_full)
    begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_wr)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = rb.wr_ok ? fpf_pkg::RESP_OKAY : fpf_pkg::RESP_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
    if (rb.rd_en)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rb.rd_data;
      next_rresp  = rb.rd_ok ? fpf_pkg::RESP_OKAY : fpf_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  // Channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end
    else
    begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end
endmodule

// >>> fpf_fan_chan.sv
// One fan channel: PWM output and blanked tachometer qualification
`timescale 1ns/1ps
module fpf_fan_chan (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Shared timebase
  input  wire logic       count_tick,
  input  wire logic [6:0] phase,
  // Settings
  input  wire logic [7:0] power,
  input  wire logic [7:0] delay,
  // Fan pins and result
  input  wire logic       tach_pin,
  output logic            fan_on,
  output logic            tach_edge
);
  logic [7:0] blank, next_blank;
  logic [2:0] sync, next_sync;
  logic       qual, next_qual, next_on, next_edge;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // On while the period phase is below the power percentage
  always_comb
  begin
    next_on    = {1'b0, phase} < power;
    next_blank = blank;
    if (next_on && !fan_on)
      next_blank = delay;
    else if (count_tick && blank != 8'h00)
      next_blank = blank - 8'h01;
    // Third stage confirms the second; first stage feeds only the second
    next_sync = {sync[1:0], tach_pin};
    next_qual = qual;
    next_edge = 1'b0;
    if (sync[1] == sync[2] && sync[2] != qual)
    begin
      next_qual = sync[2];
      next_edge = sync[2] && fan_on && blank == 8'h00;
    end
  end

  // Channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fan_on    <= 1'b0;
      blank     <= 8'h00;
      sync      <= 3'h0;
      qual      <= 1'b0;
      tach_edge <= 1'b0;
    end
    else
    begin
      fan_on    <= next_on;
      blank     <= next_blank;
      sync      <= next_sync;
      qual      <= next_qual;
      tach_edge <= next_edge;
    end
  end

  chk_blank_load: assert property ($rose(fan_on) |-> blank == $past(delay))
    else $error("blanking not loaded at turn-on");
  chk_blank_mute: assert property ((blank != 8'h00) |=> !tach_edge)
    else $error("tach edge seen while blanked");
  chk_full_on: assert property (aresetn && power == fpf_pkg::FULL_POWER |=> fan_on)
    else $error("full power did not hold fan on");
endmodule

// >>> fpf_top.sv
// Fan power controller core: packets, fail-safe timers, PWM and bus
// Notes on behaviour
// - Fail-safe mask byte must be 1 to 15
// - Fail-safe timeout counts eighth-second ticks, 1-255
// - Expired fail-safe fan forced to full power
// - Fail-safe ack is type plus 0x40, empty
// - PWM period about 18 Hz sets power
// - Tach ignored for delay counts after turn-on
// - Glitch delay defaults to one count
// - Glitch request: four counts, each 0-100
// - Glitch ack is type plus 0x40, empty
// - Glitch delays saved and restored as boot state
// - Longer delay raises reporting fan's minimum speed
// - Query returns four powers then fail-safe mask
// - Power request: four levels, each 0-100
// - Reporting fan forced full one eighth per half
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module fpf_top #(
  parameter int unsigned COUNT_CYC = fpf_pkg::COUNT_CYC,
  parameter int unsigned TICK_CYC  = fpf_pkg::TICK_CYC
) (
  // Clock and resets
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        nv_clear_n,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Fan pins
  output logic [3:0]       fan_on,
  input  wire logic [3:0]  tach_in
);
  localparam logic [14:0] CNT_LAST  = 15'(COUNT_CYC - 1);
  localparam logic [22:0] TICK_LAST = 23'(TICK_CYC - 1);

  fpf_reg_if rb ();

  logic [7:0]  power [4], next_power [4], eff_power [4];
  logic [7:0]  delay [4], next_delay [4];
  logic [7:0]  boot_delay [4], next_boot_delay [4];
  logic [7:0]  fs_cnt [4], next_fs_cnt [4];
  logic [7:0]  tach_cnt [4], next_tach_cnt [4];
  logic [7:0]  rsp_data [5], next_rsp_data [5];
  logic [3:0]  fs_mask, next_fs_mask, rpt_mask, next_rpt_mask, tach_edge;
  logic [7:0]  fs_timeout, next_fs_timeout, rsp_type, next_rsp_type;
  logic [7:0]  rsp_len, next_rsp_len, cmd_type, cmd_len;
  logic        rsp_valid, next_rsp_valid, restored, next_restored;
  logic [31:0] cmd_data, next_cmd_data, rd_word;
  logic [14:0] cyc, next_cyc;
  logic [6:0]  phase, next_phase;
  logic [22:0] tick, next_tick;
  logic [1:0]  slot, next_slot;
  logic        count_tick, eighth_tick, cmd_go, cmd_ok, rd_hit;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // All four bytes of a packed payload within 0..100
  function automatic logic all_pct(input logic [31:0] d);
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < 4; b++)
      if (d[8*b +: 8] > fpf_pkg::FULL_POWER)
        ok = 1'b0;
    return ok;
  endfunction

  fpf_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rb      (rb.slave)
  );

  // Per-fan PWM and tach channels; a reporting fan takes its own slot
  for (genvar i = 0; i < 4; i++)
  begin : g_fan
    assign eff_power[i] = (rpt_mask[i] && slot == 2'(i)) ? fpf_pkg::FULL_POWER
                                                        : power[i];
    fpf_fan_chan u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .count_tick (count_tick),
      .phase      (phase),
      .power      (eff_power[i]),
      .delay      (delay[i]),
      .tach_pin   (tach_in[i]),
      .fan_on     (fan_on[i]),
      .tach_edge  (tach_edge[i])
    );
  end

  // Timebase strobes and command decode
  assign count_tick  = cyc == CNT_LAST;
  assign eighth_tick = tick == TICK_LAST;
  assign cmd_go      = rb.wr_en && rb.wr_addr == fpf_pkg::OFS_CMD;
  assign cmd_type    = rb.wr_data[7:0];
  assign cmd_len     = rb.wr_data[15:8];
  assign rb.wr_ok    = rb.wr_addr == fpf_pkg::OFS_CMD || rb.wr_addr == fpf_pkg::OFS_CMD_DATA;

  // Packet length and payload checks; anything else earns an error reply
  always_comb
  begin
    case (cmd_type)
      fpf_pkg::CMD_STORE:    cmd_ok = cmd_len == fpf_pkg::LEN_NONE;
      fpf_pkg::CMD_REPORT:   cmd_ok = cmd_len == fpf_pkg::LEN_REPORT && cmd_data[7:4] == 4'h0;
      fpf_pkg::CMD_POWER:    cmd_ok = cmd_len == fpf_pkg::LEN_FOUR && all_pct(cmd_data);
      fpf_pkg::CMD_FAILSAFE: cmd_ok = cmd_len == fpf_pkg::LEN_FAILSAFE
                                      && cmd_data[3:0] != 4'h0 && cmd_data[7:4] == 4'h0
                                      && cmd_data[15:8] != 8'h00;
      fpf_pkg::CMD_GLITCH:   cmd_ok = cmd_len == fpf_pkg::LEN_FOUR && all_pct(cmd_data);
      fpf_pkg::CMD_QUERY:    cmd_ok = cmd_len == fpf_pkg::LEN_NONE;
      default:               cmd_ok = 1'b0;
    endcase
  end

  // Read decode; unmapped offsets answer with an error
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (rb.rd_addr)
      fpf_pkg::OFS_CMD:       rd_word = 32'h0000_0000;
      fpf_pkg::OFS_CMD_DATA:  rd_word = cmd_data;
      fpf_pkg::OFS_RSP:       rd_word = {15'h0000, rsp_valid, rsp_len, rsp_type};
      fpf_pkg::OFS_RSP_DATA:  rd_word = {rsp_data[3], rsp_data[2], rsp_data[1], rsp_data[0]};
      fpf_pkg::OFS_RSP_DATA1: rd_word = {24'h00_0000, rsp_data[4]};
      fpf_pkg::OFS_TACH:      rd_word = {tach_cnt[3], tach_cnt[2], tach_cnt[1], tach_cnt[0]};
      fpf_pkg::OFS_STATUS:    rd_word = {18'h0_0000, slot, fan_on, rpt_mask, fs_mask};
      default:                rd_hit  = 1'b0;
    endcase
  end
  assign rb.rd_data = rd_word;
  assign rb.rd_ok   = rd_hit;

  // Next state: timebase, fail-safe timers, tach counts, then commands
  always_comb
  begin
    next_power      = power;
    next_delay      = delay;
    next_boot_delay = boot_delay;
    next_fs_cnt     = fs_cnt;
    next_tach_cnt   = tach_cnt;
    next_rsp_data   = rsp_data;
    next_fs_mask    = fs_mask;
    next_rpt_mask   = rpt_mask;
    next_fs_timeout = fs_timeout;
    next_rsp_type   = rsp_type;
    next_rsp_len    = rsp_len;
    next_rsp_valid  = rsp_valid;
    next_restored   = 1'b1;
    next_cmd_data   = cmd_data;
    // 100 counts of the delay unit make one PWM period
    next_cyc   = count_tick ? 15'h0000 : cyc + 15'h0001;
    next_phase = phase;
    if (count_tick)
      next_phase = (phase == fpf_pkg::PWM_LAST) ? 7'h00 : phase + 7'h01;
    next_tick = eighth_tick ? 23'h00_0000 : tick + 23'h00_0001;
    next_slot = eighth_tick ? slot + 2'h1 : slot;
    for (int i = 0; i < 4; i++)
    begin
      if (fs_mask[i] && eighth_tick && fs_cnt[i] != 8'h00)
      begin
        next_fs_cnt[i] = fs_cnt[i] - 8'h01;
        if (fs_cnt[i] == 8'h01)
          next_power[i] = fpf_pkg::FULL_POWER;
      end
      if (tach_edge[i])
        next_tach_cnt[i] = tach_cnt[i] + 8'h01;
      if (!restored)
        next_delay[i] = boot_delay[i];
    end
    if (rb.wr_en && rb.wr_addr == fpf_pkg::OFS_CMD_DATA)
      for (int b = 0; b < 4; b++)
        if (rb.wr_strb[b])
          next_cmd_data[8*b +: 8] = rb.wr_data[8*b +: 8];
    // Reading the reply consumes it; a reply landing now still wins
    if (rb.rd_en && rb.rd_addr == fpf_pkg::OFS_RSP)
      next_rsp_valid = 1'b0;
    if (cmd_go)
    begin
      next_rsp_valid = 1'b1;
      next_rsp_type  = cmd_type | (cmd_ok ? fpf_pkg::ACK_BIT : fpf_pkg::ERR_BITS);
      next_rsp_len   = fpf_pkg::LEN_NONE;
      if (cmd_ok)
      begin
        unique case (cmd_type)
          fpf_pkg::CMD_STORE:
            next_boot_delay = delay;
          fpf_pkg::CMD_REPORT:
            next_rpt_mask = cmd_data[3:0];
          fpf_pkg::CMD_POWER:
            for (int i = 0; i < 4; i++)
            begin
              next_power[i]  = cmd_data[8*i +: 8];
              next_fs_cnt[i] = fs_timeout;
            end
          fpf_pkg::CMD_FAILSAFE:
          begin
            next_fs_mask    = cmd_data[3:0];
            next_fs_timeout = cmd_data[15:8];
            for (int i = 0; i < 4; i++)
              if (cmd_data[i])
                next_fs_cnt[i] = cmd_data[15:8];
          end
          fpf_pkg::CMD_GLITCH:
            for (int i = 0; i < 4; i++)
              next_delay[i] = cmd_data[8*i +: 8];
          fpf_pkg::CMD_QUERY:
          begin
            next_rsp_len = fpf_pkg::LEN_QUERY;
            for (int i = 0; i < 4; i++)
              next_rsp_data[i] = power[i];
            next_rsp_data[4] = {4'h0, fs_mask};
          end
        endcase
      end
    end
  end

  // Saved boot copy survives module reset; only its own clear wipes it
  always_ff @(posedge aclk)
  begin
    if (!nv_clear_n)
      boot_delay <= '{default: fpf_pkg::DELAY_DEF};
    else
      boot_delay <= next_boot_delay;
  end

  // Core registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power      <= '{default: fpf_pkg::POWER_DEF};
      delay      <= '{default: fpf_pkg::DELAY_DEF};
      fs_cnt     <= '{default: 8'h00};
      tach_cnt   <= '{default: 8'h00};
      rsp_data   <= '{default: 8'h00};
      fs_mask    <= 4'h0;
      rpt_mask   <= 4'h0;
      fs_timeout <= 8'h00;
      rsp_type   <= 8'h00;
      rsp_len    <= 8'h00;
      rsp_valid  <= 1'b0;
      restored   <= 1'b0;
      cmd_data   <= 32'h0000_0000;
      cyc        <= 15'h0000;
      phase      <= 7'h00;
      tick       <= 23'h00_0000;
      slot       <= 2'h0;
    end
    else
    begin
      power      <= next_power;
      delay      <= next_delay;
      fs_cnt     <= next_fs_cnt;
      tach_cnt   <= next_tach_cnt;
      rsp_data   <= next_rsp_data;
      fs_mask    <= next_fs_mask;
      rpt_mask   <= next_rpt_mask;
      fs_timeout <= next_fs_timeout;
      rsp_type   <= next_rsp_type;
      rsp_len    <= next_rsp_len;
      rsp_valid  <= next_rsp_valid;
      restored   <= next_restored;
      cmd_data   <= next_cmd_data;
      cyc        <= next_cyc;
      phase      <= next_phase;
      tick       <= next_tick;
      slot       <= next_slot;
    end
  end

  chk_fs_ack: assert property (cmd_go && cmd_ok && cmd_type == fpf_pkg::CMD_FAILSAFE
    |=> rsp_type == (fpf_pkg::CMD_FAILSAFE | fpf_pkg::ACK_BIT) && rsp_len == 8'h00)
    else $error("fail-safe ack wrong");
  chk_fs_mask_bad: assert property (cmd_go && cmd_type == fpf_pkg::CMD_FAILSAFE
    && cmd_data[3:0] == 4'h0 |=> rsp_type[7] && $stable(fs_mask))
    else $error("empty fail-safe mask accepted");
  chk_fs_timeout: assert property (cmd_go && cmd_ok && cmd_type == fpf_pkg::CMD_FAILSAFE
    |=> fs_timeout == $past(cmd_data[15:8]))
    else $error("fail-safe timeout not taken");
  chk_fs_expire: assert property (fs_mask[0] && fs_cnt[0] == 8'h01 && eighth_tick
    && !cmd_go |=> power[0] == fpf_pkg::FULL_POWER)
    else $error("expired fan not forced full");
  chk_fs_reload: assert property (cmd_go && cmd_ok && cmd_type == fpf_pkg::CMD_POWER
    |=> fs_cnt[1] == fs_timeout && power[1] == $past(cmd_data[15:8]))
    else $error("power write did not reload countdown");
  chk_glitch_ack: assert property (cmd_go && cmd_ok && cmd_type == fpf_pkg::CMD_GLITCH
    |=> rsp_type == (fpf_pkg::CMD_GLITCH | fpf_pkg::ACK_BIT) && delay[3] == $past(cmd_data[31:24]))
    else $error("glitch request not applied");
  chk_query_rsp: assert property (cmd_go && cmd_ok && cmd_type == fpf_pkg::CMD_QUERY
    |=> rsp_len == fpf_pkg::LEN_QUERY && rsp_data[4] == {4'h0, $past(fs_mask)}
    && rsp_data[2] == $past(power[2]))
    else $error("query reply wrong");
  chk_power_range: assert property (cmd_go && cmd_type == fpf_pkg::CMD_POWER
    && cmd_data[7:0] > fpf_pkg::FULL_POWER |=> rsp_type[7])
    else $error("power above 100 accepted");
  chk_report_slot: assert property (rpt_mask[2] && slot == 2'h2
    |=> fan_on[2])
    else $error("reporting fan not forced full");
  chk_boot_restore: assert property (!restored |=> delay[0] == $past(boot_delay[0]))
    else $error("boot delay not restored");
endmodule

// >>> fpf_fan_model.sv
// Fan model: tach pulses while powered, noise while unpowered
`timescale 1ns/1ps
module fpf_fan_model (
  // Clock
  input  wire logic       aclk,
  // Fan side
  input  wire logic [3:0] fan_on,
  output logic      [3:0] tach
);
  logic [2:0] cnt = 3'h0;
  initial tach = 4'h0;
  // An unpowered tach line is not valid, so it toggles every cycle
  always @(posedge aclk)
  begin
    cnt <= cnt + 3'h1;
    tach <= tach ^ (~fan_on | {4{cnt == 3'h0}});
  end
endmodule

// >>> fan_pwm_failsafe_control_bench.sv
// Self-checking bench for the fan power controller
`timescale 1ns/1ps
module fan_pwm_failsafe_control_bench;
  typedef struct packed {logic [31:0] m; logic [33:0] v;} fpf_exp_t;
  // Table entry: ok flag, type, length, payload
  localparam logic [48:0] TBL [8] = '{{1'b1, 16'h0400, 32'h0}, {1'b1, 16'h1001, 32'h4},
    {1'b1, 16'h1A04, 32'h64000000}, {1'b0, 16'h1A04, 32'h65000000},
    {1'b0, 16'h1902, 32'h0100}, {1'b0, 16'h1902, 32'h0001},
    {1'b0, 16'h1902, 32'h0110}, {1'b0, 16'h1104, 32'h65}};
  logic        aclk = 1'b0, aresetn = 1'b0, nv_clear_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, p, lfsr = 32'h149C;
  logic [3:0]  wstrb = 4'hF, fan_on, tach_in;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  fpf_exp_t    q[$];
  int          bad_count = 0, checks_done = 0;
  always #12.5 aclk = ~aclk;
  // Short counts keep the run brief
  fpf_top #(.COUNT_CYC(4), .TICK_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .nv_clear_n(nv_clear_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fan_on(fan_on), .tach_in(tach_in));
  fpf_fan_model fan (.aclk(aclk), .fan_on(fan_on), .tach(tach_in));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [33:0] got, input fpf_exp_t e);
    checks_done++;
    if ((got & {2'h3, e.m}) !== e.v)
    begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, e.v);
    end
  endtask
  // Each bus answer consumes the oldest note; negedge avoids edge races
  always @(negedge aclk)
    if ((rvalid && rready) || (bvalid && bready))
      cmp(bvalid ? {bresp, 32'h0} : {rresp, rdata}, q.pop_front());
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    q.push_back('{32'h0, {r, 32'h0}});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data may be taken on different edges
    do
    begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    q.push_back('{m, {r, e}});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic pkt(input logic [7:0] t, l, input logic [31:0] d, input logic [7:0] rt);
    wr(8'h04, d, 2'h0);
    wr(8'h00, {16'h0, l, t}, 2'h0);
    rd(8'h08, {16'h0001, 8'h00, rt}, '1, 2'h0);
  endtask
  task automatic query(input logic [31:0] pw, input logic [7:0] mk);
    wr(8'h00, 32'h1B, 2'h0);
    rd(8'h08, 32'h1055B, '1, 2'h0);
    rd(8'h0C, pw, '1, 2'h0);
    rd(8'h10, {24'h0, mk}, '1, 2'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run of about five hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    nv_clear_n <= 1'b1;
    query(32'h64646464, 8'h00);
    $display("test defaults done");
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      p[i*8+:8] = lfsr[7:0] % 8'd100;
    end
    pkt(8'h11, 8'h04, p, 8'h51);
    query(p, 8'h00);
    $display("test power done");
    pkt(8'h19, 8'h02, 32'h0803, 8'h59);
    repeat (100) @(posedge aclk);
    pkt(8'h11, 8'h04, p, 8'h51);
    repeat (100) @(posedge aclk);
    query(p, 8'h03);
    repeat (60) @(posedge aclk);
    query({p[31:16], 16'h6464}, 8'h03);
    rd(8'h18, 32'h303, 32'h3FF, 2'h0);
    $display("test fail-safe done");
    foreach (TBL[i])
      pkt(TBL[i][47:40], TBL[i][39:32], TBL[i][31:0], TBL[i][47:40] | (TBL[i][48] ?
        8'h40 : 8'hC0));
    $display("test packet table done");
    rd(8'h1C, 32'h0, '1, 2'h2);
    wr(8'h08, 32'h1, 2'h2);
    rd(8'h00, 32'h0, '1, 2'h0);
    $display("test bus done");
    repeat (4) @(posedge aclk);
    print_verdict();
  end
endmodule
